/* File: verilog/tcsi_top.v */
/*
 * timecode source select, loss handling, atc strip and insert
 * assumes frame, field and line strobes synchronous to clk and
 * ancillary words with a packet-kind tag from an upstream parser
 */
`timescale 1ns/1ps
`include "tcsi_defines.vh"
module tcsi_top (
  input wire clk, // 10 mhz clock
  input wire rst, // synchronous reset
  input wire [7:0] reg_addr, // register byte address
  input wire [31:0] reg_wdata, // write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  output reg [31:0] reg_rdata_r, // read data, cycle after read
  input wire [3:0] fmt_valid, // per format: timecode present
  input wire [91:0] fmt_tc, // per format 23-bit timecode
  input wire [43:0] fmt_line, // per format 11-bit line
  input wire [41:0] ltc_valid, // per ltc source: decoded ltc present
  input wire [965:0] ltc_tc, // per ltc source 23-bit timecode
  input wire serial_port_one_ltc, // serial port one set for ltc
  input wire serial_port_two_ltc, // serial port two set for ltc
  input wire frame_tick, // output frame pulse
  input wire field2, // output field is second
  input wire [10:0] out_line, // current output line
  input wire line_start, // output line start pulse
  input wire hd_out, // output is hd
  input wire scaler_en, // scaler active
  input wire [9:0] in_word, // incoming ancillary word
  input wire in_atc, // word belongs to an atc packet
  input wire in_valid, // input word valid
  output wire in_ready, // buffer ready for input
  output reg [9:0] out_word_r, // outgoing word
  output reg out_valid_r, // outgoing word valid
  input wire out_ready, // receiver ready
  output reg [22:0] ser_tc_r, // serial ltc output timecode
  output reg [22:0] aud_tc_r, // audio ltc output timecode
  output reg aud_mute_r, // audio ltc muted
  output reg ins_ltc_r, // insert atc ltc packet pulse
  output reg ins_vitc_r, // insert atc vitc packet pulse
  output reg ins_vitc_f2_r, // vitc packet of field two type
  output reg [22:0] ins_tc_r, // timecode to insert
  output reg free_run_r // output is free-running
);
  reg [31:0] ctrl_r;
  reg [5:0] src_sel_r;
  reg [7:0] prio_r;
  reg [10:0] ltc_line_r;
  reg [10:0] vitc1_line_r;
  reg [10:0] vitc2_line_r;
  reg [22:0] preset_r;
  reg [22:0] last_ext_r;
  reg ext_ok_r;
  reg [31:0] rd_nxt;
  reg [22:0] ext_tc;
  reg ext_ok;
  reg [1:0] slot_fmt;
  reg apply;
  reg [9:0] buf1_r;
  reg [1:0] cnt_r;
  wire [22:0] free_tc;
  wire [3:0] fmt_present;
  wire strip;
  wire push;
  wire pop;
  integer k;
  integer m;
  reg [22:0] run_tc;

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  // control writes, apply is a self-clearing pulse bit
  always @(posedge clk) begin
    if (rst) begin
      ctrl_r <= 32'h00000000;
      src_sel_r <= `TCSI_SRC_SER1;
      prio_r <= `TCSI_PRIO_RST;
      ltc_line_r <= `TCSI_LTC_LINE_RST;
      vitc1_line_r <= `TCSI_VITC1_LINE_RST;
      vitc2_line_r <= `TCSI_VITC2_LINE_RST;
      preset_r <= 23'h000000;
    end else begin
      ctrl_r[`TCSI_CTRL_APPLY] <= 1'b0;
      if (reg_wr) begin
        if (reg_addr == `TCSI_REG_CTRL) begin
          ctrl_r <= {26'h0000000, reg_wdata[5:0]};
        end else if (reg_addr == `TCSI_REG_SRC) begin
          if (reg_wdata[5:0] <= `TCSI_SRC_LAST) begin
            src_sel_r <= reg_wdata[5:0];
          end
        end else if (reg_addr == `TCSI_REG_PRIO) begin
          prio_r <= reg_wdata[7:0];
        end else if (reg_addr == `TCSI_REG_LINES) begin
          ltc_line_r <= reg_wdata[10:0];
          vitc1_line_r <= reg_wdata[26:16];
        end else if (reg_addr == `TCSI_REG_VLINE2) begin
          vitc2_line_r <= reg_wdata[10:0];
        end else if (reg_addr == `TCSI_REG_PRESET) begin
          preset_r <= {reg_wdata[22:6], 6'h00};
        end
      end
    end
  end

  // read mux, unmapped reads zero
  always @* begin
    rd_nxt = 32'h00000000;
    if (reg_addr == `TCSI_REG_CTRL) begin
      rd_nxt = ctrl_r;
    end else if (reg_addr == `TCSI_REG_SRC) begin
      rd_nxt = {26'h0000000, src_sel_r};
    end else if (reg_addr == `TCSI_REG_PRIO) begin
      rd_nxt = {24'h000000, prio_r};
    end else if (reg_addr == `TCSI_REG_LINES) begin
      rd_nxt = {5'h00, vitc1_line_r, 5'h00, ltc_line_r};
    end else if (reg_addr == `TCSI_REG_VLINE2) begin
      rd_nxt = {21'h000000, vitc2_line_r};
    end else if (reg_addr == `TCSI_REG_PRESET) begin
      rd_nxt = {9'h000, preset_r};
    end else if (reg_addr == `TCSI_REG_OUT_TC) begin
      rd_nxt = {9'h000, ser_tc_r};
    end else if (reg_addr == `TCSI_REG_STATUS) begin
      rd_nxt = {24'h000000, aud_mute_r, free_run_r, ext_ok_r, 1'b0, fmt_present};
    end else begin
      for (k = 0; k < 4; k = k + 1) begin
        if (reg_addr == `TCSI_REG_FMT_BASE + {k[4:0], 3'h0}) begin
          rd_nxt = fmt_valid[k] ? {9'h100, fmt_tc[k*23 +: 23]} : 32'h00000000;
        end else if (reg_addr == `TCSI_REG_FMT_BASE + {k[4:0], 3'h4}) begin
          rd_nxt = fmt_valid[k] ? {21'h000000, fmt_line[k*11 +: 11]} : 32'h00000000;
        end
      end
    end
  end

  // read data register
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata_r <= 32'h00000000;
    end else begin
      reg_rdata_r <= reg_rd ? rd_nxt : 32'h00000000;
    end
  end

  // ------------------------------------------------------------
  // source selection
  // ------------------------------------------------------------
  // format 3 presence comes from the chosen ltc source
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_fmt
      assign fmt_present[g] = fmt_valid[g];
    end
  endgenerate
  assign fmt_present[3] = ltc_valid[src_sel_r] &
    ((src_sel_r != `TCSI_SRC_SER1 || serial_port_one_ltc) &&
     (src_sel_r != `TCSI_SRC_SER2 || serial_port_two_ltc));

  // priority walk over four slots
  always @* begin
    ext_ok = 1'b0;
    ext_tc = 23'h000000;
    slot_fmt = 2'h0;
    for (m = 3; m >= 0; m = m - 1) begin
      slot_fmt = prio_r[m*2 +: 2];
      if (fmt_present[slot_fmt]) begin
        ext_ok = 1'b1;
        ext_tc = (slot_fmt == 2'h3) ? ltc_tc[src_sel_r*23 +: 23] :
          fmt_tc[slot_fmt*23 +: 23];
      end
    end
  end

  // ------------------------------------------------------------
  // free run and loss handling
  // ------------------------------------------------------------
  // load only in free run
  always @* begin
    apply = ctrl_r[`TCSI_CTRL_APPLY] & free_run_r;
  end

  // seed shown at loss
  // first loss cycle shows the seed, not the stale count
  always @* begin
    run_tc = ext_ok_r ? last_ext_r : free_tc;
  end

  tcsi_free_counter u_free (
    .clk(clk),
    .rst(rst),
    .frame_max(`TCSI_FRAMES_RST),
    .load(apply | (ext_ok_r & ~ext_ok)),
    .load_tc(apply ? preset_r : last_ext_r),
    .tick(frame_tick & ~apply),
    .tc_r(free_tc)
  );

  // outputs of timecode path
  always @(posedge clk) begin
    if (rst) begin
      last_ext_r <= 23'h000000;
      ext_ok_r <= 1'b0;
      ser_tc_r <= 23'h000000;
      aud_tc_r <= 23'h000000;
      aud_mute_r <= 1'b0;
      free_run_r <= 1'b1;
      ins_tc_r <= 23'h000000;
    end else begin
      ext_ok_r <= ext_ok;
      if (ext_ok) begin
        last_ext_r <= ext_tc;
        ser_tc_r <= ext_tc;
        aud_tc_r <= ext_tc;
        ins_tc_r <= ext_tc;
        aud_mute_r <= 1'b0;
        free_run_r <= 1'b0;
      end else if (ctrl_r[`TCSI_CTRL_MUTE]) begin
        aud_mute_r <= 1'b1;
        free_run_r <= 1'b0;
        ins_tc_r <= run_tc;
      end else begin
        ser_tc_r <= run_tc;
        aud_tc_r <= run_tc;
        ins_tc_r <= run_tc;
        aud_mute_r <= 1'b0;
        free_run_r <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // insertion requests
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      ins_ltc_r <= 1'b0;
      ins_vitc_r <= 1'b0;
      ins_vitc_f2_r <= 1'b0;
    end else begin
      ins_ltc_r <= line_start & hd_out & ctrl_r[`TCSI_CTRL_LTC_EN] &
        (out_line == ltc_line_r);
      ins_vitc_r <= line_start & hd_out & ctrl_r[`TCSI_CTRL_VITC_EN] &
        (out_line == (field2 ? vitc2_line_r : vitc1_line_r));
      ins_vitc_f2_r <= field2 & ~ctrl_r[`TCSI_CTRL_LEGACY];
    end
  end

  // ------------------------------------------------------------
  // ancillary strip with two-entry buffer
  // ------------------------------------------------------------
  // strip atc words when removal set or scaler active
  assign strip = in_atc & (ctrl_r[`TCSI_CTRL_REMOVE] | scaler_en);
  assign in_ready = (cnt_r != 2'h2);
  assign push = in_valid & in_ready & ~strip;
  assign pop = out_valid_r & out_ready;

  // buffer: head in out_word_r, second in buf1_r
  always @(posedge clk) begin
    if (rst) begin
      cnt_r <= 2'h0;
      buf1_r <= 10'h000;
      out_word_r <= 10'h000;
      out_valid_r <= 1'b0;
    end else begin
      if (push && !pop) begin
        cnt_r <= cnt_r + 2'h1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 2'h1;
      end
      if (pop) begin
        if (cnt_r == 2'h2) begin
          out_word_r <= buf1_r;
          if (push) begin
            buf1_r <= in_word;
          end
        end else if (push) begin
          out_word_r <= in_word;
        end
        out_valid_r <= (cnt_r == 2'h2) | push;
      end else if (push) begin
        if (cnt_r == 2'h0) begin
          out_word_r <= in_word;
          out_valid_r <= 1'b1;
        end else begin
          buf1_r <= in_word;
        end
      end
    end
  end
endmodule

/* File: verilog/tcsi_defines.vh */
/*
 * shared constants of the timecode select and insert block
 * assumes inclusion by bare name from verilog files of this block
 */
`ifndef TCSI_DEFINES_VH
`define TCSI_DEFINES_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define TCSI_REG_CTRL     8'h00
`define TCSI_REG_SRC      8'h04
`define TCSI_REG_PRIO     8'h08
`define TCSI_REG_LINES    8'h0c
`define TCSI_REG_VLINE2   8'h10
`define TCSI_REG_PRESET   8'h14
`define TCSI_REG_OUT_TC   8'h18
`define TCSI_REG_STATUS   8'h1c
`define TCSI_REG_FMT_BASE 8'h20

// ------------------------------------------------------------
// control bits
// ------------------------------------------------------------
`define TCSI_CTRL_MUTE    0
`define TCSI_CTRL_REMOVE  1
`define TCSI_CTRL_LTC_EN  2
`define TCSI_CTRL_VITC_EN 3
`define TCSI_CTRL_LEGACY  4
`define TCSI_CTRL_APPLY   5

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define TCSI_LTC_LINE_RST   11'h00a
`define TCSI_VITC1_LINE_RST 11'h009
`define TCSI_VITC2_LINE_RST 11'h110
`define TCSI_PRIO_RST       8'he4

// ------------------------------------------------------------
// ltc source encodings
// ------------------------------------------------------------
`define TCSI_SRC_SER1   6'h00
`define TCSI_SRC_SER2   6'h01
`define TCSI_SRC_EMB0   6'h02
`define TCSI_SRC_AES0   6'h12
`define TCSI_SRC_ANA0   6'h22
`define TCSI_SRC_LAST   6'h29

// ------------------------------------------------------------
// timecode limits
// ------------------------------------------------------------
`define TCSI_FRAMES_RST 5'h1d
`define TCSI_SEC_MAX    6'h3b
`define TCSI_HOUR_MAX   5'h17

`endif

/* File: verilog/tcsi_free_counter.v */
/*
 * free running timecode counter with load
 * assumes one frame pulse per output frame on clk
 */
`timescale 1ns/1ps
`include "tcsi_defines.vh"
module tcsi_free_counter (
  input wire clk, // system clock
  input wire rst, // synchronous reset
  input wire [4:0] frame_max, // last frame number
  input wire load, // load pulse
  input wire [22:0] load_tc, // hh mm ss ff to load
  input wire tick, // one per output frame
  output reg [22:0] tc_r // hh(5) mm(6) ss(6) ff(6)
);
  reg [22:0] tc_nxt;

  // frame advance with carries
  always @* begin
    tc_nxt = tc_r;
    if (load) begin
      tc_nxt = load_tc;
    end else if (tick) begin
      if (tc_r[5:0] < {1'b0, frame_max}) begin
        tc_nxt[5:0] = tc_r[5:0] + 6'h01;
      end else begin
        tc_nxt[5:0] = 6'h00;
        if (tc_r[11:6] < `TCSI_SEC_MAX) begin
          tc_nxt[11:6] = tc_r[11:6] + 6'h01;
        end else begin
          tc_nxt[11:6] = 6'h00;
          if (tc_r[17:12] < `TCSI_SEC_MAX) begin
            tc_nxt[17:12] = tc_r[17:12] + 6'h01;
          end else begin
            tc_nxt[17:12] = 6'h00;
            if (tc_r[22:18] < `TCSI_HOUR_MAX) begin
              tc_nxt[22:18] = tc_r[22:18] + 5'h01;
            end else begin
              tc_nxt[22:18] = 5'h00;
            end
          end
        end
      end
    end
  end

  // counter register
  always @(posedge clk) begin
    if (rst) begin
      tc_r <= 23'h000000;
    end else begin
      tc_r <= tc_nxt;
    end
  end
endmodule

/* File: bench/tcsi_top_chk.sv */
/*
 * port assertions for the timecode select and insert block
 * assumes a bind onto tcsi_top, one clock with active high sync reset
 */
`timescale 1ns/1ps
module tcsi_top_chk (
  input logic clk, // clock
  input logic rst, // sync reset
  input logic [7:0] reg_addr, // register address
  input logic reg_rd, // read strobe
  input logic [31:0] reg_rdata_r, // read data
  input logic line_start, // line pulse
  input logic hd_out, // hd output
  input logic in_ready, // buffer ready
  input logic out_ready, // receiver ready
  input logic out_valid_r, // word valid
  input logic [9:0] out_word_r, // word
  input logic [22:0] ser_tc_r, // serial timecode
  input logic [22:0] aud_tc_r, // audio timecode
  input logic aud_mute_r, // audio muted
  input logic free_run_r, // free running
  input logic ins_ltc_r, // ltc insert pulse
  input logic ins_vitc_r // vitc insert pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // read data only in the slot after a read
  chk_rd_slot: assert property (!$past(reg_rd) |-> reg_rdata_r == 32'h0)
    else $error("read data outside its slot");
  chk_rd_unmapped: assert property (reg_rd && reg_addr >= 8'h40 |=> reg_rdata_r == 32'h0)
    else $error("unmapped read not zero");
  chk_mute_freeze: assert property (
    aud_mute_r && $past(aud_mute_r) |-> $stable(ser_tc_r) && !free_run_r)
    else $error("muted output not frozen");
  chk_free_both: assert property (
    free_run_r |-> aud_tc_r == ser_tc_r && !aud_mute_r)
    else $error("free run outputs differ");
  chk_free_range: assert property (
    free_run_r |-> ser_tc_r[5:0] <= 6'h1d && ser_tc_r[11:6] <= 6'h3b
      && ser_tc_r[22:18] <= 5'h17)
    else $error("free count out of range");
  chk_ltc_cause: assert property (ins_ltc_r |-> $past(line_start && hd_out))
    else $error("ltc insert without hd line");
  chk_vitc_cause: assert property ($rose(ins_vitc_r) |-> $past(line_start && hd_out))
    else $error("vitc insert without hd line");
  chk_ltc_single: assert property (ins_ltc_r |=> !ins_ltc_r)
    else $error("ltc insert pulse too long");
  chk_out_hold: assert property (out_valid_r && !out_ready |=> out_valid_r && $stable(out_word_r))
    else $error("stalled word not held");
  chk_full_valid: assert property (!in_ready |-> out_valid_r)
    else $error("full buffer shows no word");
endmodule

bind tcsi_top tcsi_top_chk u_tcsi_top_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .line_start(line_start), .hd_out(hd_out),
  .in_ready(in_ready), .out_ready(out_ready), .out_valid_r(out_valid_r),
  .out_word_r(out_word_r), .ser_tc_r(ser_tc_r), .aud_tc_r(aud_tc_r),
  .aud_mute_r(aud_mute_r), .free_run_r(free_run_r), .ins_ltc_r(ins_ltc_r),
  .ins_vitc_r(ins_vitc_r));

/* File: bench/tcsi_src_model.sv */
/*
 * model of the timecode sources: four formats and 42 ltc inputs
 * assumes the bench sets presence; frames count 0..29 per frame pulse
 */
`timescale 1ns/1ps
module tcsi_src_model (
  input logic clk, // clock
  input logic rst, // sync reset
  input logic frame_tick, // frame pulse
  input logic [3:0] fmt_on, // formats sending
  input logic [41:0] ltc_on, // ltc inputs sending
  output logic [3:0] fmt_valid, // format present
  output logic [91:0] fmt_tc, // format timecode
  output logic [43:0] fmt_line, // format line
  output logic [41:0] ltc_valid, // ltc present
  output logic [965:0] ltc_tc // ltc timecode
);
  logic [5:0] cnt_r;

  // running frame count shared by all sources
  always @(posedge clk) begin
    if (rst) cnt_r <= 6'h0;
    else if (frame_tick) cnt_r <= (cnt_r == 6'h1d) ? 6'h0 : cnt_r + 6'h1;
  end

  // silent sources show the inverse pattern, never a stale count
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      fmt_tc[k*23+:23] = {5'(20 + k), 6'h3b, 6'h3b, cnt_r} ^ {23{~fmt_on[k]}};
      fmt_line[k*11+:11] = 11'(13 + k);
    end
    for (int i = 0; i < 42; i++) begin
      ltc_tc[i*23+:23] = {5'h04, 6'(i), 6'h09, cnt_r} ^ {23{~ltc_on[i]}};
    end
  end
  assign fmt_valid = fmt_on;
  assign ltc_valid = ltc_on;
endmodule

/* File: bench/tcsi_top_tb_top.sv */
/*
 * self-checking bench for the timecode select and insert block
 * assumes the source model and the bound checker are compiled alongside
 */
`timescale 1ns/1ps
module tcsi_top_tb_top;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, frame_tick = 0, field2 = 0;
  logic line_start = 0, hd_out = 0, scaler_en = 0, in_atc = 0, in_valid = 0, out_ready = 0;
  logic sp_one = 1, sp_two = 1;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata_r, rd_d;
  logic [10:0] out_line = 11'h0;
  logic [9:0] in_word = 10'h0, out_word_r;
  logic [3:0] fmt_on = 4'h0, fmt_valid;
  logic [41:0] ltc_on = 42'h0, ltc_valid;
  logic [91:0] fmt_tc;
  logic [43:0] fmt_line;
  logic [965:0] ltc_tc;
  logic [22:0] ser_tc_r, aud_tc_r, ins_tc_r;
  logic in_ready, out_valid_r, aud_mute_r, ins_ltc_r, ins_vitc_r, ins_vitc_f2_r, free_run_r;
  logic [9:0] exp_q[$];
  int fail_count = 0, n_compared = 0, cycles = 0, frames = 0;
  int srcs[8] = '{0, 1, 2, 17, 18, 33, 34, 41};

  tcsi_top u_tcsi_top (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r,
    .fmt_valid, .fmt_tc, .fmt_line, .ltc_valid, .ltc_tc, .serial_port_one_ltc(sp_one),
    .serial_port_two_ltc(sp_two), .frame_tick, .field2, .out_line, .line_start, .hd_out,
    .scaler_en, .in_word, .in_atc, .in_valid, .in_ready, .out_word_r, .out_valid_r,
    .out_ready, .ser_tc_r, .aud_tc_r, .aud_mute_r, .ins_ltc_r, .ins_vitc_r, .ins_vitc_f2_r,
    .ins_tc_r, .free_run_r);
  tcsi_src_model u_tcsi_src_model (.clk, .rst, .frame_tick, .fmt_on, .ltc_on, .fmt_valid,
    .fmt_tc, .fmt_line, .ltc_valid, .ltc_tc);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial forever #50 clk = ~clk;

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict;
    end
  end

  function logic [22:0] fmt_exp(input int k);
    return {5'(20 + k), 6'h3b, 6'h3b, 6'(frames)};
  endfunction
  function logic [22:0] ltc_exp(input int i);
    return {5'h04, 6'(i), 6'h09, 6'(frames)};
  endfunction

  task chk(input [31:0] got, input [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_d = reg_rdata_r;
  endtask
  task tick;
    @(posedge clk);
    frame_tick <= 1'b1;
    @(posedge clk);
    frame_tick <= 1'b0;
    frames = (frames == 29) ? 0 : frames + 1;
  endtask
  task set_src(input [3:0] f, input [41:0] l);
    @(posedge clk);
    fmt_on <= f;
    ltc_on <= l;
    cyc(3);
  endtask
  task ins_case(input [10:0] l, input f, input [2:0] e);
    @(posedge clk);
    out_line <= l;
    field2 <= f;
    line_start <= 1'b1;
    @(posedge clk);
    line_start <= 1'b0;
    #1 chk({ins_ltc_r, ins_vitc_r, ins_vitc_f2_r}, e);
  endtask
  task push(input [9:0] w, input a);
    @(posedge clk);
    in_word <= w;
    in_atc <= a;
    in_valid <= 1'b1;
    do @(negedge clk); while (in_ready !== 1'b1);
  endtask
  task drain;
    @(posedge clk);
    in_valid <= 1'b0;
    out_ready <= 1'b1;
    repeat (8) begin
      @(negedge clk);
      if (out_valid_r === 1'b1) chk(out_word_r, exp_q.pop_front());
    end
    chk(exp_q.size(), 0);
    @(posedge clk);
    out_ready <= 1'b0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task reset_regs;
    rd(8'h0c); chk(rd_d, 32'h0009000a);
    rd(8'h10); chk(rd_d, 32'h110);
    rd(8'h08); chk(rd_d, 32'he4);
    rd(8'h40); chk(rd_d, 32'h0);
    rd(8'h1c); chk(rd_d, 32'h40);
  endtask
  task fmt_status;
    set_src(4'h3, 42'h0);
    chk(ser_tc_r, fmt_exp(0));
    rd(8'h20); chk(rd_d, {9'h100, fmt_exp(0)});
    rd(8'h2c); chk(rd_d, 32'he);
    rd(8'h30); chk(rd_d, 32'h0);
    rd(8'h34); chk(rd_d, 32'h0);
  endtask
  task src_select;
    wr(8'h08, 32'hff);
    foreach (srcs[j]) begin
      wr(8'h04, srcs[j]);
      set_src(4'h3, 42'h1 << srcs[j]);
      chk(ser_tc_r, ltc_exp(srcs[j]));
      chk(aud_tc_r, ltc_exp(srcs[j]));
    end
    wr(8'h04, 32'h2a);
    rd(8'h04); chk(rd_d, 32'h29);
    // serial sources count only while their port is set for ltc
    @(posedge clk);
    sp_one <= 1'b0;
    sp_two <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      wr(8'h04, p);
      set_src(4'h3, 42'h1 << p);
      rd(8'h1c); chk(rd_d, 32'h43);
    end
    @(posedge clk);
    sp_one <= 1'b1;
    sp_two <= 1'b1;
  endtask
  task failover;
    wr(8'h08, 32'h07);
    set_src(4'h3, 42'h0);
    chk(ser_tc_r, fmt_exp(1));
    set_src(4'h1, 42'h0);
    chk(ser_tc_r, fmt_exp(0));
  endtask
  task mute_loss;
    logic [22:0] h;
    wr(8'h00, 32'h1);
    h = fmt_exp(0);
    set_src(4'h0, 42'h0);
    chk({aud_mute_r, free_run_r}, 2'b10);
    tick;
    cyc(3);
    chk(ser_tc_r, h);
    chk(aud_tc_r, h);
    chk(ins_tc_r, fmt_exp(0));
    wr(8'h00, 32'h21);
    cyc(3);
    chk(ins_tc_r, fmt_exp(0));
  endtask
  task free_loss;
    set_src(4'h1, 42'h0);
    wr(8'h00, 32'h0);
    while (frames != 29) tick;
    set_src(4'h0, 42'h0);
    chk({aud_mute_r, free_run_r}, 2'b01);
    chk(ser_tc_r, {5'd20, 6'h3b, 6'h3b, 6'h1d});
    tick;
    cyc(3);
    chk(ser_tc_r, {5'd21, 18'h0});
    chk(aud_tc_r, {5'd21, 18'h0});
  endtask
  task preset;
    wr(8'h14, 32'h1c0015);
    wr(8'h00, 32'h20);
    cyc(3);
    chk(ser_tc_r, 32'h1c0000);
    rd(8'h18); chk(rd_d, 32'h1c0000);
    wr(8'h14, 32'h0c0000);
    set_src(4'h1, 42'h0);
    wr(8'h00, 32'h20);
    cyc(3);
    chk(ser_tc_r, fmt_exp(0));
  endtask
  task insert;
    @(posedge clk);
    hd_out <= 1'b1;
    wr(8'h00, 32'h0c);
    ins_case(11'd10, 1'b0, 3'b100);
    ins_case(11'd9, 1'b0, 3'b010);
    ins_case(11'd272, 1'b1, 3'b011);
    ins_case(11'd272, 1'b0, 3'b000);
    wr(8'h0c, 32'h0009000c);
    ins_case(11'd10, 1'b0, 3'b000);
    ins_case(11'd12, 1'b0, 3'b100);
    wr(8'h00, 32'h18);
    ins_case(11'd272, 1'b1, 3'b010);
    ins_case(11'd12, 1'b0, 3'b000);
    @(posedge clk);
    hd_out <= 1'b0;
    ins_case(11'd9, 1'b0, 3'b000);
  endtask
  task stream;
    wr(8'h00, 32'h2);
    push(10'h101, 1'b0);
    push(10'h2aa, 1'b1);
    push(10'h103, 1'b0);
    @(posedge clk);
    in_valid <= 1'b0;
    @(negedge clk);
    chk(in_ready, 1'b0);
    exp_q = '{10'h101, 10'h103};
    drain;
    wr(8'h00, 32'h0);
    scaler_en <= 1'b1;
    push(10'h2aa, 1'b1);
    push(10'h105, 1'b0);
    exp_q = '{10'h105};
    drain;
    scaler_en <= 1'b0;
    push(10'h2ab, 1'b1);
    exp_q = '{10'h2ab};
    drain;
  endtask

  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    reset_regs;
    fmt_status;
    src_select;
    failover;
    mute_loss;
    free_loss;
    preset;
    insert;
    stream;
    print_verdict;
  end
endmodule
